// File: verilog/emccd_clock_sequencer.sv
`default_nettype none
// Contract
// - Multiplication barrier rises only after its stage gate is high; barrier one rises with stage one when pixel clocking ends.
// - Multiplication barrier falls no later than its stage gate.
// - Second barrier and stage fall together as first stage rises.
// - Packets above threshold go to normal gain, others to multiplier.
// - Multiplier route: low-gain gate low, multiplier gate follows phase two.
// - Routing applies 28 pixel steps after sensing.
// - Front-end clamp happens within first 28 pixel steps of each row.
// - No pixel period shorter than 50 ns.
// - Binning clocks the horizontal register at 20 MHz; the code uses 7 core cycles, 56 ns.
// - First vertical interval lasts 1.2 us to 2.0 us.
// - Second vertical interval lasts 1.2 us to 4.0 us.
// - Photodiode transfer pulse lasts 3.0 us to 5.0 us.
// - No multiplier edges while shutter pulse is high.
// - Static gates during frame, line and shutter: phase one high.
// - Reverse direction by swapping a register's barrier waveforms.
// - Unused horizontal registers hold every gate high.
// - Single mode: second bottom barriers swapped, top gates high.
// - Dual mode: both bottom registers get identical waveforms; the code swaps register a's barriers against b's when reverse is set.
// - Quad mode: top registers also get identical waveforms.
// - Multiplication high level is set per quadrant, shared by stages.
module emccd_clock_sequencer
  import emccd_seq_pkg::*;
#(
  parameter int AFE_W        = 14,
  parameter int ROUTE_DELAY  = 28,
  parameter int MULT_STAGES  = 1800,
  parameter int CLAMP_PIXELS = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic [4:0]       i_avs_address,
  input  wire logic             i_avs_read,
  input  wire logic             i_avs_write,
  input  wire logic [31:0]      i_avs_writedata,
  input  wire logic [3:0]       i_avs_byteenable,
  output logic [31:0]           o_avs_readdata,
  output logic                  o_avs_waitrequest,
  input  wire logic [AFE_W-1:0] i_afe_data,
  output logic                  o_afe_clamp,
  output logic                  o_shutter,
  output logic                  o_pd_transfer,
  output logic                  o_vline_first,
  output logic                  o_vline_second,
  output logic                  o_vpattern_quad,
  output logic                  o_mult_stage_phase1,
  output logic                  o_mult_stage_phase2,
  output logic                  o_mult_barrier_phase1,
  output logic                  o_mult_barrier_phase2,
  output logic [31:0]           o_mult_high_level,
  output logic                  o_route_gate_common,
  output logic                  o_route_gate_lowgain,
  output logic                  o_route_gate_multiplier,
  output logic                  o_sense_gate_reset,
  output logic                  o_sense_exit_gate,
  output logic                  o_last_gate_phase2,
  output logic                  o_hreg_store_phase1_bot,
  output logic                  o_hreg_store_phase2_bot,
  output logic                  o_hreg_barrier_phase1_a,
  output logic                  o_hreg_barrier_phase2_a,
  output logic                  o_hreg_barrier_phase1_b,
  output logic                  o_hreg_barrier_phase2_b,
  output logic                  o_hreg_store_phase1_top,
  output logic                  o_hreg_store_phase2_top,
  output logic                  o_hreg_barrier_phase1_top,
  output logic                  o_hreg_barrier_phase2_top
);

  if (AFE_W < 1 || AFE_W > 16 || ROUTE_DELAY < 2 || CLAMP_PIXELS < 1 ||
      CLAMP_PIXELS > 28 || MULT_STAGES < 1 || MULT_STAGES > 30000)
  begin : g_chk
    $error("emccd_clock_sequencer parameters out of range");
  end

  localparam logic [15:0] FLUSH   = 16'(MULT_STAGES);
  localparam logic [15:0] CLAMP_N = 16'(CLAMP_PIXELS);
  localparam logic [7:0]  PIX_MIN = 8'(PIX_MIN_CYC);
  localparam logic [7:0]  PIX_BIN = 8'(BIN_PIX_CYC);
  localparam logic [7:0]  BAR_D   = 8'(BAR_DLY);

  typedef struct packed {
    seq_state_t  st;
    logic [8:0]  tcnt;
    logic [7:0]  pc;
    logic [15:0] pix;
    logic [15:0] row;
    logic [15:0] frames;
    logic        shut_en;
    logic [1:0]  mode;
    logic        reverse;
    logic        bin_en;
    logic [15:0] nh;
    logic [15:0] nv;
    logic [7:0]  pixcyc;
    logic [15:0] thresh;
    logic [31:0] level;
    logic        ack;
    logic [31:0] rdata;
    logic        clamp;
    logic        shut;
    logic        pd;
    logic        vfirst;
    logic        vsecond;
    logic        ms1;
    logic        ms2;
    logic        mb1;
    logic        mb2;
    logic        rt_com;
    logic        rt_low;
    logic        rt_mult;
    logic        sense;
    logic [9:0]  hreg;
  } seq_t;

  seq_t s_reg;
  seq_t s_next;

  logic       step;
  logic       bright_now;
  logic       bright_due;
  logic [7:0] eff_cyc;
  logic [7:0] half;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [8:0] cyc(input int n);
    return 9'(n - 1);
  endfunction : cyc

  assign eff_cyc = s_reg.bin_en ? PIX_BIN : s_reg.pixcyc;
  assign half = {1'b0, eff_cyc[7:1]};
  assign step = (s_reg.st == ST_PIX) && (s_reg.pc == eff_cyc - 8'h01);
  assign bright_now = 16'(i_afe_data) > s_reg.thresh;

  // The front end delivers the sensed sample of each packet on this step.
  route_delay #(
    .DEPTH (ROUTE_DELAY)
  ) u_route_delay (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_step     (step),
    .i_bit      (bright_now),
    .o_bit      (bright_due)
  );

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !s_reg.ack;

  always_comb
  begin
    logic [31:0] wr;
    logic        act;
    logic        h2;
    logic        p1;
    logic        p2;
    wr = 32'h0;
    s_next = s_reg;
    s_next.ack = 1'b0;
    act = s_reg.st == ST_PIX;
    h2 = act && (s_reg.pc >= half);
    p1 = !h2;
    p2 = h2;

    // Bus: one wait cycle; write lands on the edge after it, while waitrequest is low.
    if ((i_avs_read || i_avs_write) && !s_reg.ack)
    begin
      s_next.ack = 1'b1;
      case (i_avs_address)
        OFS_CTRL:   s_next.rdata = {26'h0, s_reg.bin_en, s_reg.reverse,
                                    s_reg.mode, s_reg.shut_en, 1'b0};
        OFS_STATUS: s_next.rdata = {s_reg.row, 15'h0,
                                    s_reg.st != ST_IDLE};
        OFS_NH:     s_next.rdata = {16'h0, s_reg.nh};
        OFS_NV:     s_next.rdata = {16'h0, s_reg.nv};
        OFS_PIXCYC: s_next.rdata = {24'h0, s_reg.pixcyc};
        OFS_THRESH: s_next.rdata = {16'h0, s_reg.thresh};
        OFS_LEVEL:  s_next.rdata = s_reg.level;
        OFS_FRAMES: s_next.rdata = {16'h0, s_reg.frames};
        default:    s_next.rdata = 32'h0;
      endcase
    end
    if (i_avs_write && s_reg.ack)
    begin
      case (i_avs_address)
        OFS_CTRL:
        begin
          wr = merge({26'h0, s_reg.bin_en, s_reg.reverse, s_reg.mode,
                      s_reg.shut_en, 1'b0}, i_avs_writedata,
                     i_avs_byteenable);
          s_next.shut_en = wr[CTRL_SHUT_EN];
          s_next.mode    = wr[CTRL_MODE_LO +: 2];
          s_next.reverse = wr[CTRL_REVERSE];
          s_next.bin_en  = wr[CTRL_BIN_EN];
        end
        OFS_NH:
        begin
          wr = merge({16'h0, s_reg.nh}, i_avs_writedata, i_avs_byteenable);
          s_next.nh = (wr[15:0] == 16'h0) ? 16'h1 : wr[15:0];
        end
        OFS_NV:
        begin
          wr = merge({16'h0, s_reg.nv}, i_avs_writedata, i_avs_byteenable);
          s_next.nv = (wr[15:0] == 16'h0) ? 16'h1 : wr[15:0];
        end
        OFS_PIXCYC:
        begin
          wr = merge({24'h0, s_reg.pixcyc}, i_avs_writedata,
                     i_avs_byteenable);
          s_next.pixcyc = (wr[7:0] < PIX_MIN) ? PIX_MIN : wr[7:0];
        end
        OFS_THRESH:
        begin
          wr = merge({16'h0, s_reg.thresh}, i_avs_writedata,
                     i_avs_byteenable);
          s_next.thresh = wr[15:0];
        end
        OFS_LEVEL:
          s_next.level = merge(s_reg.level, i_avs_writedata,
                               i_avs_byteenable);
        default:
          s_next.level = s_reg.level;
      endcase
    end

    // Frame sequencer.
    case (s_reg.st)
      ST_IDLE:
      begin
        if (i_avs_write && s_reg.ack && i_avs_address == OFS_CTRL &&
            i_avs_byteenable[0] && i_avs_writedata[CTRL_START])
        begin
          s_next.row = 16'h0;
          if (wr[CTRL_SHUT_EN])
          begin
            s_next.st   = ST_SHUT;
            s_next.tcnt = cyc(SUB_CYC);
          end
          else
          begin
            s_next.st   = ST_PD;
            s_next.tcnt = cyc(PD_CYC);
          end
        end
      end
      ST_SHUT:
      begin
        s_next.tcnt = s_reg.tcnt - 9'h1;
        if (s_reg.tcnt == 9'h0)
        begin
          s_next.st   = ST_PD;
          s_next.tcnt = cyc(PD_CYC);
        end
      end
      ST_PD:
      begin
        s_next.tcnt = s_reg.tcnt - 9'h1;
        if (s_reg.tcnt == 9'h0)
        begin
          s_next.st   = ST_VA;
          s_next.tcnt = cyc(VA_CYC);
        end
      end
      ST_VA:
      begin
        s_next.tcnt = s_reg.tcnt - 9'h1;
        if (s_reg.tcnt == 9'h0)
        begin
          s_next.st   = ST_VB;
          s_next.tcnt = cyc(VB_CYC);
        end
      end
      ST_VB:
      begin
        s_next.tcnt = s_reg.tcnt - 9'h1;
        if (s_reg.tcnt == 9'h0)
        begin
          s_next.st  = ST_PIX;
          s_next.pc  = 8'h0;
          s_next.pix = 16'h0;
        end
      end
      ST_PIX:
      begin
        s_next.pc = s_reg.pc + 8'h01;
        if (step)
        begin
          s_next.pc  = 8'h0;
          s_next.pix = s_reg.pix + 16'h1;
          // Keep clocking after the last pixel until the multiplier is empty.
          if (s_reg.pix == s_reg.nh + FLUSH - 16'h1)
          begin
            s_next.row = s_reg.row + 16'h1;
            if (s_reg.row == s_reg.nv - 16'h1)
            begin
              s_next.st     = ST_IDLE;
              s_next.frames = s_reg.frames + 16'h1;
            end
            else
            begin
              s_next.st   = ST_VA;
              s_next.tcnt = cyc(VA_CYC);
            end
          end
        end
      end
      default:
        s_next.st = ST_IDLE;
    endcase

    // Gate patterns; outside pixel clocking phase one stays high.
    s_next.shut    = s_reg.st == ST_SHUT;
    s_next.pd      = s_reg.st == ST_PD;
    s_next.vfirst  = s_reg.st == ST_VA;
    s_next.vsecond = s_reg.st == ST_VB;
    s_next.clamp   = act && (s_reg.pix < CLAMP_N);
    s_next.ms1     = p1;
    s_next.ms2     = p2;
    s_next.mb1     = act ? (!h2 && s_reg.pc >= BAR_D &&
                            s_reg.pc + 8'h01 < half) : 1'b1;
    s_next.mb2     = h2 && (s_reg.pc >= half + BAR_D);
    s_next.rt_com  = p2;
    s_next.rt_low  = p2 && bright_due;
    s_next.rt_mult = p2 && !bright_due;
    s_next.sense   = p2;
    // hreg: sto1 sto2 a_b1 a_b2 b_b1 b_b2 top_s1 top_s2 top_b1 top_b2.
    s_next.hreg[9:8] = {p1, p2};
    s_next.hreg[7:6] = s_reg.reverse ? {p2, p1} : {p1, p2};
    if (s_reg.mode == MODE_SINGLE)
    begin
      s_next.hreg[5:4] = {p2, p1};
    end
    else
    begin
      s_next.hreg[5:4] = {p1, p2};
    end
    if (s_reg.mode == MODE_SINGLE || s_reg.mode == MODE_DUAL)
    begin
      s_next.hreg[3:0] = 4'hf;
    end
    else
    begin
      s_next.hreg[3:0] = {p1, p2, p1, p2};
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_reg        <= '0;
      s_reg.st     <= ST_IDLE;
      s_reg.nh     <= NH_RST;
      s_reg.nv     <= NV_RST;
      s_reg.pixcyc <= PIXCYC_RST;
      s_reg.thresh <= THRESH_RST;
      s_reg.level  <= LEVEL_RST;
      s_reg.ms1    <= 1'b1;
      s_reg.mb1    <= 1'b1;
      s_reg.hreg   <= 10'h2af;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_avs_readdata          = s_reg.rdata;
  assign o_afe_clamp             = s_reg.clamp;
  assign o_shutter               = s_reg.shut;
  assign o_pd_transfer           = s_reg.pd;
  assign o_vline_first           = s_reg.vfirst;
  assign o_vline_second          = s_reg.vsecond;
  assign o_vpattern_quad         = s_reg.mode[1];
  assign o_mult_stage_phase1     = s_reg.ms1;
  assign o_mult_stage_phase2     = s_reg.ms2;
  assign o_mult_barrier_phase1   = s_reg.mb1;
  assign o_mult_barrier_phase2   = s_reg.mb2;
  assign o_mult_high_level       = s_reg.level;
  assign o_route_gate_common     = s_reg.rt_com;
  assign o_route_gate_lowgain    = s_reg.rt_low;
  assign o_route_gate_multiplier = s_reg.rt_mult;
  assign o_sense_gate_reset      = s_reg.sense;
  assign o_sense_exit_gate       = s_reg.sense;
  assign o_last_gate_phase2      = s_reg.ms2;
  assign {o_hreg_store_phase1_bot, o_hreg_store_phase2_bot,
          o_hreg_barrier_phase1_a, o_hreg_barrier_phase2_a,
          o_hreg_barrier_phase1_b, o_hreg_barrier_phase2_b,
          o_hreg_store_phase1_top, o_hreg_store_phase2_top,
          o_hreg_barrier_phase1_top, o_hreg_barrier_phase2_top} = s_reg.hreg;

  // Helper: length of the vertical pulse that is high now.
  logic [9:0] vh_cnt;
  logic       v_any;
  assign v_any = o_pd_transfer || o_vline_first || o_vline_second;
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      vh_cnt <= 10'h0;
    end
    else if ($changed({o_pd_transfer, o_vline_first, o_vline_second}))
    begin
      vh_cnt <= 10'h1;
    end
    else
    begin
      vh_cnt <= vh_cnt + 10'h1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_shutter_quiet: assert property (o_shutter |-> $stable(o_mult_stage_phase2)
    && o_mult_stage_phase1 && !o_mult_barrier_phase2)
    else $error("multiplier clocked during shutter");
  a_static_gates: assert property (v_any |-> o_mult_stage_phase1 &&
    !o_mult_stage_phase2 && !o_route_gate_common && !o_sense_exit_gate &&
    o_hreg_store_phase1_bot && !o_hreg_store_phase2_bot)
    else $error("gates not static during line or frame");
  a_barrier_rise: assert property ($rose(o_mult_barrier_phase2) |->
    o_mult_stage_phase2 && $past(o_mult_stage_phase2))
    else $error("barrier rose before stage gate");
  a_barrier1_fall: assert property ($fell(o_mult_stage_phase1) |->
    !o_mult_barrier_phase1 && $past(!o_mult_barrier_phase1))
    else $error("barrier one not low before stage falls");
  a_step_return: assert property ($fell(o_mult_stage_phase2) |->
    !o_mult_barrier_phase2 && $rose(o_mult_stage_phase1))
    else $error("stage return not simultaneous");
  a_route_excl: assert property (!(o_route_gate_lowgain &&
    o_route_gate_multiplier) && (o_route_gate_common ==
    (o_route_gate_lowgain || o_route_gate_multiplier)))
    else $error("route gates inconsistent");
  a_pd_width: assert property ($fell(o_pd_transfer) |->
    vh_cnt == 10'(PD_CYC))
    else $error("photodiode transfer width wrong");
  a_vfirst_width: assert property ($fell(o_vline_first) |->
    vh_cnt == 10'(VA_CYC) && o_vline_second)
    else $error("first vertical interval wrong");
  a_vsecond_width: assert property ($fell(o_vline_second) |->
    vh_cnt == 10'(VB_CYC))
    else $error("second vertical interval wrong");
  a_clamp_window: assert property (o_afe_clamp |->
    s_reg.pix <= 16'h1c)
    else $error("clamp outside line start");
  a_top_idle: assert property (!s_reg.mode[1] |=>
    o_hreg_store_phase1_top && o_hreg_barrier_phase2_top)
    else $error("unused top register not held high");

  c_shutter_frame: cover property ($fell(o_shutter) ##1 o_pd_transfer);
  c_route_mult: cover property (o_route_gate_multiplier);
  c_route_low: cover property (o_route_gate_lowgain);
  c_frame_done: cover property ($changed(s_reg.frames));

endmodule : emccd_clock_sequencer
`default_nettype wire

// File: verilog/emccd_seq_pkg.sv
`default_nettype none
package emccd_seq_pkg;

  localparam int CLK_NS = 8;

  // Pulse and interval times in ns, and their cycle counts at the core rate.
  localparam int T_VA_NS    = 1200;
  localparam int T_VB_NS    = 1200;
  localparam int T_SUB_NS   = 2500;
  localparam int T_PD_NS    = 3000;
  localparam int PIX_MIN_NS = 50;
  localparam int BIN_PIX_NS = 50;
  localparam int VA_CYC      = (T_VA_NS + CLK_NS - 1) / CLK_NS;
  localparam int VB_CYC      = (T_VB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUB_CYC     = (T_SUB_NS + CLK_NS - 1) / CLK_NS;
  localparam int PD_CYC      = (T_PD_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIX_MIN_CYC = (PIX_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIN_PIX_CYC = (BIN_PIX_NS + CLK_NS - 1) / CLK_NS;
  localparam int BAR_DLY     = 1;

  // Register byte offsets.
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_NH     = 5'h08;
  localparam logic [4:0] OFS_NV     = 5'h0c;
  localparam logic [4:0] OFS_PIXCYC = 5'h10;
  localparam logic [4:0] OFS_THRESH = 5'h14;
  localparam logic [4:0] OFS_LEVEL  = 5'h18;
  localparam logic [4:0] OFS_FRAMES = 5'h1c;

  // Control field positions.
  localparam int CTRL_START   = 0;
  localparam int CTRL_SHUT_EN = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_REVERSE = 4;
  localparam int CTRL_BIN_EN  = 5;

  // Output modes.
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL   = 2'h1;
  localparam logic [1:0] MODE_QUAD   = 2'h2;

  // Reset values.
  localparam logic [15:0] NH_RST     = 16'h090c;
  localparam logic [15:0] NV_RST     = 16'h0860;
  localparam logic [7:0]  PIXCYC_RST = 8'h07;
  localparam logic [15:0] THRESH_RST = 16'h007e;
  localparam logic [31:0] LEVEL_RST  = 32'h0;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SHUT = 6'h02,
    ST_PD   = 6'h04,
    ST_VA   = 6'h08,
    ST_VB   = 6'h10,
    ST_PIX  = 6'h20
  } seq_state_t;

endpackage : emccd_seq_pkg
`default_nettype wire

// File: verilog/route_delay.sv
`default_nettype none
module route_delay
  import emccd_seq_pkg::*;
#(
  parameter int DEPTH = 28
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_step,
  input  wire logic i_bit,
  output logic      o_bit
);

  if (DEPTH < 2)
  begin : g_chk
    $error("route_delay needs DEPTH of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0] line;
  } delay_state_t;

  delay_state_t s_reg;
  delay_state_t s_next;

  // Bright is the safe default: unknown packets never reach the multiplier.
  always_comb
  begin
    s_next = s_reg;
    if (i_step)
    begin
      s_next.line = {s_reg.line[DEPTH-2:0], i_bit};
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_reg <= '1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_bit = s_reg.line[DEPTH-1];

endmodule : route_delay
`default_nettype wire

// File: verification/afe_sensor_model.sv
`default_nettype none
module afe_sensor_model
  import emccd_seq_pkg::*;
#(
  parameter logic [13:0] LEVEL = 14'h0200
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hreg_store_phase2,
  input  wire logic        i_mult_stage_phase2,
  output logic [13:0]      o_afe_data,
  output logic [31:0]      o_stage_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stage_q;

  // Outside the sensing half the line carries the inverse level, so a
  // stale sample is never held for the controller to pick up late.
  assign o_afe_data = i_hreg_store_phase2 ? LEVEL : ~LEVEL;

  // Each rise of the second stage phase moves every packet one stage on.
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      stage_q       <= 1'b0;
      o_stage_count <= 32'h0;
    end
    else
    begin
      stage_q <= i_mult_stage_phase2;
      if (i_mult_stage_phase2 && !stage_q)
        o_stage_count <= o_stage_count + 32'h1;
    end
  end
endmodule : afe_sensor_model
`default_nettype wire

// File: verification/testbench.sv
`default_nettype none
module testbench;
  import emccd_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 4;
  localparam int CP = 8;
  logic        i_core_clk, i_rst, i_avs_read, i_avs_write;
  logic [4:0]  i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, o_mult_high_level;
  logic [31:0] q, cfg, stages;
  logic [3:0]  i_avs_byteenable;
  logic [13:0] i_afe_data;
  logic        o_avs_waitrequest, o_afe_clamp, o_shutter, o_pd_transfer;
  logic        o_vline_first, o_vline_second, o_vpattern_quad;
  logic        o_mult_stage_phase1, o_mult_stage_phase2;
  logic        o_mult_barrier_phase1, o_mult_barrier_phase2;
  logic        o_route_gate_common, o_route_gate_lowgain;
  logic        o_route_gate_multiplier, o_sense_gate_reset;
  logic        o_sense_exit_gate, o_last_gate_phase2;
  logic        o_hreg_store_phase1_bot, o_hreg_store_phase2_bot;
  logic        o_hreg_barrier_phase1_a, o_hreg_barrier_phase2_a;
  logic        o_hreg_barrier_phase1_b, o_hreg_barrier_phase2_b;
  logic        o_hreg_store_phase1_top, o_hreg_store_phase2_top;
  logic        o_hreg_barrier_phase1_top, o_hreg_barrier_phase2_top;
  logic        act, lg_q, mx_q, swp;
  int          fail_count, n_compared, st_bad, md_bad, n_low, n_mult;

  emccd_clock_sequencer #(
    .MULT_STAGES  (MS),
    .CLAMP_PIXELS (CP)
  ) emccd_clock_sequencer_i (.*);

  afe_sensor_model afe_sensor_model_i (
    .i_core_clk          (i_core_clk),
    .i_rst               (i_rst),
    .i_hreg_store_phase2 (o_hreg_store_phase2_bot),
    .i_mult_stage_phase2 (o_mult_stage_phase2),
    .o_afe_data          (i_afe_data),
    .o_stage_count       (stages)
  );

  initial
  begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  initial
  begin
    repeat (40000) @(posedge i_core_clk);
    fail_count++;
    end_of_test;
  end

  // Sampled at the falling edge, where every registered gate has settled.
  always @(negedge i_core_clk)
  begin
    swp = (cfg[3:2] == MODE_SINGLE) ^ cfg[CTRL_REVERSE];
    if ((o_shutter | o_pd_transfer | o_vline_first | o_vline_second) &&
        {o_mult_stage_phase1, o_mult_barrier_phase1, o_hreg_store_phase1_bot,
         o_mult_stage_phase2, o_mult_barrier_phase2, o_hreg_store_phase2_bot,
         o_route_gate_common, o_last_gate_phase2, o_sense_exit_gate,
         o_sense_gate_reset} !== 10'h380)
      st_bad++;
    if (act && o_hreg_barrier_phase1_a !==
        (swp ? o_hreg_barrier_phase2_b : o_hreg_barrier_phase1_b))
      md_bad++;
    if (act && (cfg[3] ?
        ({o_hreg_store_phase1_top, o_hreg_store_phase2_top} !==
         {o_hreg_store_phase1_bot, o_hreg_store_phase2_bot}) :
        ({o_hreg_store_phase1_top, o_hreg_store_phase2_top,
          o_hreg_barrier_phase1_top, o_hreg_barrier_phase2_top} !== 4'hf)))
      md_bad++;
    n_low += int'(o_route_gate_lowgain && !lg_q);
    n_mult += int'(o_route_gate_multiplier && !mx_q);
    lg_q = o_route_gate_lowgain;
    mx_q = o_route_gate_multiplier;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Entered just after a rising edge; holds the request until the edge
  // at which waitrequest is seen low, then lets one edge pass idle.
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    i_avs_read      <= !w;
    i_avs_write     <= w;
    i_avs_address   <= a;
    i_avs_writedata <= d;
    do @(posedge i_core_clk); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_core_clk);
  endtask : bus

  task rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask : rchk

  function automatic logic sig(input int k);
    case (k)
      0: return o_shutter;
      1: return o_pd_transfer;
      2: return o_vline_first;
      3: return o_vline_second;
      default: return o_afe_clamp;
    endcase
  endfunction : sig

  task automatic pulse(input int k, input int exp);
    int n;
    n = 0;
    while (sig(k) !== 1'b1) @(negedge i_core_clk);
    while (sig(k) === 1'b1)
    begin
      n++;
      @(negedge i_core_clk);
    end
    check(n, exp);
  endtask : pulse

  task automatic frame(input logic [31:0] c, input int nv, input int nh,
                       input logic [15:0] th, input int eff);
    int          total;
    int          lo;
    logic [31:0] s0;
    total = nv * (nh + MS);
    lo = (th == 16'hffff) ? ((total < 28) ? total : 28) : total;
    bus(1'b1, OFS_NV, nv);
    bus(1'b1, OFS_NH, nh);
    bus(1'b1, OFS_THRESH, {16'h0, th});
    st_bad = 0;
    md_bad = 0;
    n_low = 0;
    n_mult = 0;
    s0 = stages;
    cfg = c;
    bus(1'b1, OFS_CTRL, c | 32'h1);
    act = 1'b1;
    check(o_vpattern_quad, c[3]);
    if (c[CTRL_SHUT_EN])
      pulse(0, SUB_CYC);
    pulse(1, PD_CYC);
    pulse(2, VA_CYC);
    pulse(3, VB_CYC);
    pulse(4, ((nh + MS < CP) ? nh + MS : CP) * eff);
    @(posedge i_core_clk);
    do bus(1'b0, OFS_STATUS, 32'h0); while (q[0] !== 1'b0);
    act = 1'b0;
    check(stages - s0, total);
    check(st_bad, 0);
    check(md_bad, 0);
    check(n_low, lo);
    check(n_mult, total - lo);
    $display("frame test done, mode %0d", c[3:2]);
  endtask : frame

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial
  begin
    i_rst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 5'h0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'hf;
    cfg = 32'h0;
    act = 1'b0;
    lg_q = 1'b0;
    mx_q = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    rchk(OFS_NH, NH_RST);
    rchk(OFS_NV, NV_RST);
    rchk(OFS_THRESH, THRESH_RST);
    rchk(OFS_LEVEL, LEVEL_RST);
    rchk(OFS_PIXCYC, PIXCYC_RST);
    bus(1'b1, OFS_PIXCYC, 32'h3);
    rchk(OFS_PIXCYC, 32'h7);
    bus(1'b1, OFS_LEVEL, 32'h44332211);
    i_avs_byteenable <= 4'h2;
    bus(1'b1, OFS_LEVEL, 32'hffffffff);
    i_avs_byteenable <= 4'hf;
    rchk(OFS_LEVEL, 32'h4433ff11);
    check(o_mult_high_level, 32'h4433ff11);
    $display("register test done");
    frame(32'h02, 2, 2, 16'h007e, 7);
    bus(1'b1, OFS_PIXCYC, 32'h9);
    frame(32'h28, 1, 2, 16'h007e, 7);
    frame(32'h04, 1, 2, 16'h007e, 9);
    frame(32'h14, 1, 40, 16'hffff, 9);
    end_of_test;
  end
endmodule : testbench
`default_nettype wire
